// ### rtl/mst_mul_sub_xfer.sv
/*
 * Execution datapath for the multiply-and-subtract-low (word and chain)
 * and multiply-and-move-low instructions, with accumulator file,
 * accumulator pointers, product registers, flags and register port.
 * Assumes a sequencer on the same clock that offers one command at a
 * time while busy is low, and a data memory that answers a read request
 * with mem_rvalid a cycle or more later.
 */
`timescale 1ns/100ps
`default_nettype none
`include "mst_regs.svh"

// Overview of operation
// RULE_01 - the multiplier operand times the source forms a 32-bit product whose top 16 bits go to the product-high register.
// RULE_02 - the word subtract form takes the low 16 product bits, kept in product-low, away from the destination accumulator.
// RULE_03 - the chain subtract form takes product-low away from a multi-word destination accumulator string.
// RULE_04 - the move form copies the low 16 product bits into the selected accumulator and still loads product-high.
// RULE_05 - every form sets sign and zero from the written value; overflow and carry come from the subtraction and are cleared by the move form.
// RULE_06 - a source fetched from data memory also sets the tag flag from the fetched word's tag.
// RULE_07 - a coded pointer modification on a word register form is applied before the multiply and update.
// RULE_08 - memory forms are two words, the second giving a direct address or a long relative offset.
// RULE_09 - the word subtract register form is 11100, modify field, selector, 110000, and two offset select bits.
// RULE_10 - the chain subtract register form matches the word form but with bits 11 and 10 both one.
// RULE_11 - the word register form may name the base accumulator or its offset partner for source and destination.
// RULE_12 - a predecrement lowers the chosen pointer first and both operands then use the new pointer.
// RULE_13 - a string spans the chain length register value plus two words and the product is sized to match.
// RULE_14 - a chain subtraction runs from the lowest word upward with borrow and flags from the whole result.
// RULE_15 - bit 1 picks the offset accumulator as source and bit 0 as destination, zero meaning the base one.
module mst_mul_sub_xfer #(
    parameter int ACC_DEPTH = 16,
    parameter int PTR_W = 4
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic cmd_valid,
    input wire mst_pkg::mst_cmd_type cmd,
    output logic busy,
    output logic done,
    output logic illegal,
    output logic mem_req,
    output logic [15:0] mem_addr,
    output logic mem_rel,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_tag,
    input wire logic mem_rvalid,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic [15:0] product_high_reg,
    output logic [15:0] product_low_reg,
    output mst_pkg::mst_flags_type flags
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_MUL,
        ST_CHAIN
    } mst_state_type;

    mst_state_type state;
    logic [15:0] acc [ACC_DEPTH];
    logic [PTR_W-1:0] accum_pointer [4];
    logic [15:0] multiplier_operand_reg;
    logic [PTR_W-1:0] chain_length_reg;
    mst_pkg::mst_kind_type kind;
    logic [1:0] accum_sel;
    logic src_off;
    logic dst_off;
    logic [PTR_W-1:0] chain_k;
    logic [15:0] chain_carry;
    logic chain_nb;
    logic chain_zero;

    // decode of the offered command
    logic take;
    logic is_reg;
    logic reg_sub;
    logic reg_mov;
    logic reg_chain;
    logic mem_sub;
    logic mem_mov;
    logic legal;
    logic [1:0] mod;

    assign take = cmd_valid && !busy;
    assign mod = cmd.op[11:10];
    assign is_reg = cmd.op[16:12] == `MST_OP_REG_HI; // see RULE_09
    assign reg_sub = is_reg && cmd.op[7:2] == `MST_OP_SUB_LO; // see RULE_09
    assign reg_chain = reg_sub && mod == `MST_MOD_CHAIN; // see RULE_10
    assign reg_mov = is_reg && cmd.op[7:2] == `MST_OP_MOV_LO && mod != `MST_MOD_CHAIN;
    assign mem_sub = cmd.op[16:10] == `MST_OP_MEM_SUB; // see RULE_08
    assign mem_mov = cmd.op[16:10] == `MST_OP_MEM_MOV; // see RULE_08
    assign legal = reg_sub || reg_mov || mem_sub || mem_mov;

    // offset partner flips the pointer's top bit so a string of up to 8 words never overlaps it
    function automatic logic [PTR_W-1:0] acc_index(input logic [PTR_W-1:0] ptr,
                                                   input logic off,
                                                   input logic [PTR_W-1:0] k);
        logic [PTR_W-1:0] base;
        base = off ? {~ptr[PTR_W-1], ptr[PTR_W-2:0]} : ptr; // see RULE_11
        return base + k;
    endfunction

    logic [PTR_W-1:0] src_idx;
    logic [PTR_W-1:0] dst_idx;
    logic [15:0] src_word;
    logic [15:0] dst_word;
    logic exec_word;
    logic chain_last;
    logic [31:0] prod;
    logic [15:0] sub_word;
    logic [16:0] diff;
    logic [15:0] result;
    logic res_ov;
    logic res_cy;

    // pointer is read after premodify, since state moves on only after the take edge
    assign src_idx = acc_index(accum_pointer[accum_sel], src_off, chain_k); // see RULE_15
    assign dst_idx = acc_index(accum_pointer[accum_sel], dst_off, chain_k); // see RULE_15
    assign dst_word = acc[dst_idx];
    assign src_word = (state == ST_FETCH) ? mem_rdata : acc[src_idx];
    assign exec_word = (state == ST_MUL) || (state == ST_FETCH && mem_rvalid);
    assign chain_last = chain_k == PTR_W'(chain_length_reg + 2'd1); // see RULE_13

    mst_mul_step u_mul (
        .a(multiplier_operand_reg),
        .b(src_word),
        .carry_in((state == ST_CHAIN) ? chain_carry : 16'h0000),
        .product(prod)
    );

    // only the lowest chain word sees product-low; higher words only borrow
    always_comb begin
        sub_word = (state == ST_CHAIN && chain_k != '0) ? 16'h0000 : prod[15:0];
        diff = {1'b0, dst_word} + {1'b0, ~sub_word}
               + {16'h0000, (state == ST_CHAIN) ? chain_nb : 1'b1}; // see RULE_14
        if (kind == mst_pkg::MST_KIND_MOV_WORD) begin
            result = prod[15:0]; // see RULE_04
            res_ov = 1'b0;
            res_cy = 1'b0;
        end else begin
            result = diff[15:0]; // see RULE_02
            res_ov = (dst_word[15] ^ sub_word[15]) & (dst_word[15] ^ diff[15]);
            res_cy = diff[16];
        end
    end

    // sequencing
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b0;
            illegal <= 1'b0;
            kind <= mst_pkg::MST_KIND_SUB_WORD;
            accum_sel <= 2'h0;
            src_off <= 1'b0;
            dst_off <= 1'b0;
            chain_k <= '0;
        end else begin
            done <= 1'b0;
            illegal <= take && !legal;
            case (state)
                ST_IDLE: begin
                    if (take && legal) begin
                        busy <= 1'b1;
                        accum_sel <= cmd.op[9:8];
                        chain_k <= '0;
                        src_off <= is_reg && cmd.op[1]; // see RULE_15
                        dst_off <= is_reg && cmd.op[0]; // see RULE_15
                        if (reg_mov || mem_mov) begin
                            kind <= mst_pkg::MST_KIND_MOV_WORD;
                        end else if (reg_chain) begin
                            kind <= mst_pkg::MST_KIND_SUB_CHAIN;
                        end else begin
                            kind <= mst_pkg::MST_KIND_SUB_WORD;
                        end
                        if (mem_sub || mem_mov) begin
                            state <= ST_FETCH;
                        end else if (reg_chain) begin
                            state <= ST_CHAIN;
                        end else begin
                            state <= ST_MUL;
                        end
                    end
                end
                ST_FETCH, ST_MUL: begin
                    if (exec_word) begin
                        state <= ST_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
                ST_CHAIN: begin
                    chain_k <= chain_k + 1'b1;
                    if (chain_last) begin
                        state <= ST_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    busy <= 1'b0;
                end
            endcase
        end
    end

    // memory request of the two-word forms
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mem_req <= 1'b0;
            mem_addr <= `MST_RST_WORD;
            mem_rel <= 1'b0;
        end else begin
            mem_req <= take && (mem_sub || mem_mov); // see RULE_08
            if (take && (mem_sub || mem_mov)) begin
                mem_addr <= cmd.ext; // see RULE_08
                mem_rel <= cmd.op[`MST_ADRS_REL_BIT];
            end
        end
    end

    // accumulator pointers: premodify at the take edge, ahead of any operand read
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < 4; i++) begin
                accum_pointer[i] <= '0;
            end
        end else if (take && (reg_sub || reg_mov) && !reg_chain
                     && mod != `MST_MOD_NONE) begin
            if (mod == `MST_MOD_DEC) begin
                accum_pointer[cmd.op[9:8]] <= accum_pointer[cmd.op[9:8]] - 1'b1; // see RULE_12
            end else begin
                accum_pointer[cmd.op[9:8]] <= accum_pointer[cmd.op[9:8]] + 1'b1; // see RULE_07
            end
        end else if (reg_wr && reg_addr == `MST_OFF_PTRS) begin
            for (int i = 0; i < 4; i++) begin
                accum_pointer[i] <= reg_wdata[i*PTR_W +: PTR_W];
            end
        end
    end

    // accumulator file; the datapath wins over a same-cycle register write
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < ACC_DEPTH; i++) begin
                acc[i] <= `MST_RST_WORD;
            end
        end else if (exec_word || state == ST_CHAIN) begin
            acc[dst_idx] <= result; // see RULE_03
        end else if (reg_wr && reg_addr >= `MST_OFF_ACC
                     && reg_addr < 8'(`MST_OFF_ACC + ACC_DEPTH)) begin
            acc[PTR_W'(reg_addr - `MST_OFF_ACC)] <= reg_wdata;
        end
    end

    // chain running state: multiply carry word, no-borrow bit, zero so far
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            chain_carry <= `MST_RST_WORD;
            chain_nb <= 1'b1;
            chain_zero <= 1'b1;
        end else if (state == ST_CHAIN && !chain_last) begin
            chain_carry <= prod[31:16]; // see RULE_13
            chain_nb <= diff[16]; // see RULE_14
            chain_zero <= chain_zero && result == 16'h0000;
        end else begin
            chain_carry <= `MST_RST_WORD;
            chain_nb <= 1'b1;
            chain_zero <= 1'b1;
        end
    end

    // product registers and flags
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            product_high_reg <= `MST_RST_WORD;
            product_low_reg <= `MST_RST_WORD;
            flags <= `MST_RST_FLAGS;
        end else begin
            if (exec_word) begin
                product_high_reg <= prod[31:16]; // see RULE_01
                product_low_reg <= prod[15:0];
                flags.overflow_flag <= res_ov; // see RULE_05
                flags.sign_flag <= result[15];
                flags.zero_flag <= result == 16'h0000;
                flags.carry_flag <= res_cy;
                if (state == ST_FETCH) begin
                    flags.tag <= mem_tag; // see RULE_06
                end
            end
            if (state == ST_CHAIN && chain_k == '0) begin
                product_low_reg <= prod[15:0];
            end
            if (state == ST_CHAIN && chain_last) begin
                product_high_reg <= prod[31:16]; // see RULE_13
                flags.overflow_flag <= res_ov; // see RULE_14
                flags.sign_flag <= result[15];
                flags.zero_flag <= chain_zero && result == 16'h0000;
                flags.carry_flag <= res_cy;
            end
        end
    end

    // register port: operand and length writes, read data one cycle later
    logic [15:0] ptr_packed;
    always_comb begin
        ptr_packed = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            ptr_packed[i*PTR_W +: PTR_W] = accum_pointer[i];
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            multiplier_operand_reg <= `MST_RST_WORD;
            chain_length_reg <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `MST_OFF_MR) begin
                multiplier_operand_reg <= reg_wdata;
            end
            if (reg_addr == `MST_OFF_CHAIN) begin
                chain_length_reg <= reg_wdata[PTR_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= `MST_RST_WORD;
        end else if (reg_rd) begin
            if (reg_addr >= `MST_OFF_ACC && reg_addr < 8'(`MST_OFF_ACC + ACC_DEPTH)) begin
                reg_rdata <= acc[PTR_W'(reg_addr - `MST_OFF_ACC)];
            end else begin
                case (reg_addr)
                    `MST_OFF_MR: reg_rdata <= multiplier_operand_reg;
                    `MST_OFF_CHAIN: reg_rdata <= 16'(chain_length_reg);
                    `MST_OFF_PH: reg_rdata <= product_high_reg;
                    `MST_OFF_PL: reg_rdata <= product_low_reg;
                    `MST_OFF_FLAGS: reg_rdata <= {11'h000, flags};
                    `MST_OFF_PTRS: reg_rdata <= ptr_packed;
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // helper: cycles spent in the chain loop
    logic [PTR_W:0] chain_cycles;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            chain_cycles <= '0;
        end else if (state == ST_CHAIN) begin
            chain_cycles <= chain_cycles + 1'b1;
        end else begin
            chain_cycles <= '0;
        end
    end

    chk_ph_from_product: assert property (@(posedge clock) disable iff (!resetn) // see RULE_01
        exec_word |=> product_high_reg == $past(prod[31:16]) && done)
        else $error("product high not loaded from product");

    chk_word_sub_result: assert property (@(posedge clock) disable iff (!resetn) // see RULE_02
        exec_word && kind == mst_pkg::MST_KIND_SUB_WORD
        |=> acc[$past(dst_idx)] == 16'($past(dst_word) - $past(prod[15:0])))
        else $error("word subtract result wrong");

    chk_move_result: assert property (@(posedge clock) disable iff (!resetn) // see RULE_04
        exec_word && kind == mst_pkg::MST_KIND_MOV_WORD
        |=> acc[$past(dst_idx)] == product_low_reg && !flags.carry_flag)
        else $error("move low result wrong");

    chk_zero_flag: assert property (@(posedge clock) disable iff (!resetn) // see RULE_05
        exec_word |=> flags.zero_flag == (acc[$past(dst_idx)] == 16'h0000)
                      && flags.sign_flag == acc[$past(dst_idx)][15])
        else $error("zero or sign flag does not match result");

    chk_tag_capture: assert property (@(posedge clock) disable iff (!resetn) // see RULE_06
        state == ST_FETCH && mem_rvalid |=> flags.tag == $past(mem_tag))
        else $error("tag flag not taken from fetched word");

    chk_predecrement: assert property (@(posedge clock) disable iff (!resetn) // see RULE_12
        take && reg_sub && mod == `MST_MOD_DEC
        |=> accum_pointer[$past(cmd.op[9:8])] == $past(accum_pointer[cmd.op[9:8]]) - 1'b1
            ##1 acc[$past(dst_idx)] == 16'($past(dst_word) - $past(prod[15:0])))
        else $error("predecrement not applied before update");

    chk_two_word_req: assert property (@(posedge clock) disable iff (!resetn) // see RULE_08
        take && (mem_sub || mem_mov) |=> mem_req && mem_addr == $past(cmd.ext)
                                         && state == ST_FETCH)
        else $error("memory form did not request second word address");

    chk_decode_reject: assert property (@(posedge clock) disable iff (!resetn) // see RULE_09
        take && !legal |=> illegal && !busy)
        else $error("undecoded command not flagged");

    chk_chain_length: assert property (@(posedge clock) disable iff (!resetn) // see RULE_13
        state == ST_CHAIN && chain_last |=> chain_cycles == $past(chain_length_reg) + 2'd2
                                            && done)
        else $error("chain did not span length plus two words");

    chk_chain_start: assert property (@(posedge clock) disable iff (!resetn) // see RULE_10
        take && reg_chain |=> state == ST_CHAIN && chain_k == '0 ##1 chain_k == 1)
        else $error("chain form did not start at lowest word");

endmodule // mst_mul_sub_xfer

`default_nettype wire

// ### rtl/mst_regs.svh
/*
 * Register offsets, reset values, opcode fields and pointer-modify codes
 * of the multiply/subtract/transfer datapath.
 * Assumes inclusion by bare name from any file that needs the numbers.
 */
`ifndef MST_REGS_SVH
`define MST_REGS_SVH

// register port offsets (word addresses on the plain register port)
`define MST_OFF_MR 8'h00
`define MST_OFF_CHAIN 8'h01
`define MST_OFF_PH 8'h02
`define MST_OFF_PL 8'h03
`define MST_OFF_FLAGS 8'h04
`define MST_OFF_PTRS 8'h05
`define MST_OFF_ACC 8'h10

// reset values
`define MST_RST_WORD 16'h0000
`define MST_RST_FLAGS 5'h00

// register-form fields
`define MST_OP_REG_HI 5'h1C
`define MST_OP_SUB_LO 6'h30
`define MST_OP_MOV_LO 6'h36
// memory-form fields, bits 16..10
`define MST_OP_MEM_SUB 7'h3F
`define MST_OP_MEM_MOV 7'h30
// bit of the address field that picks a long relative offset
`define MST_ADRS_REL_BIT 7

// pointer-modify codes in bits 11..10
`define MST_MOD_NONE 2'h0
`define MST_MOD_INC 2'h1
`define MST_MOD_DEC 2'h2
`define MST_MOD_CHAIN 2'h3

`endif

// ### rtl/mst_pkg.sv
/*
 * Types shared by the multiply/subtract/transfer datapath.
 * Assumes mst_regs.svh for all numeric constants.
 */
package mst_pkg;

    typedef enum logic [1:0] {
        MST_KIND_SUB_WORD,
        MST_KIND_SUB_CHAIN,
        MST_KIND_MOV_WORD
    } mst_kind_type;

    typedef struct packed {
        logic [16:0] op;
        logic [15:0] ext;
    } mst_cmd_type;

    typedef struct packed {
        logic tag;
        logic overflow_flag;
        logic sign_flag;
        logic zero_flag;
        logic carry_flag;
    } mst_flags_type;

endpackage

// ### rtl/mst_mul_step.sv
/*
 * One 16x16 multiply step with an added carry word.
 * Assumes unsigned operands; the sum never exceeds 32 bits.
 */
`timescale 1ns/100ps
`default_nettype none

module mst_mul_step (
    input wire logic [15:0] a,
    input wire logic [15:0] b,
    input wire logic [15:0] carry_in,
    output logic [31:0] product
);
    // widen before multiplying so the upper product half is never lost
    assign product = {16'h0000, a} * {16'h0000, b} + {16'h0000, carry_in};
endmodule // mst_mul_step

`default_nettype wire

// ### tb/mst_mem_model.sv
/*
 * Behavioural data memory that answers the datapath's operand fetches.
 * Assumes one outstanding request at a time, on the core clock.
 */
`timescale 1ns/100ps
`default_nettype none

module mst_mem_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic mem_rel,
    output logic [15:0] mem_rdata,
    output logic mem_tag,
    output logic mem_rvalid
);
    logic pend;
    logic rel;
    logic [1:0] wait_cnt;
    logic [15:0] addr;

    // delay follows the low address bits, so prompt and slow answers both occur
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pend <= 1'h0;
            rel <= 1'h0;
            wait_cnt <= 2'h0;
            addr <= 16'h0;
            mem_rdata <= 16'h0;
            mem_tag <= 1'h0;
            mem_rvalid <= 1'h0;
        end else begin
            mem_rvalid <= 1'h0;
            // no stale word outside an answer
            mem_rdata <= ~mem_rdata;
            if (mem_req) begin
                pend <= 1'h1;
                wait_cnt <= mem_addr[1:0];
                addr <= mem_addr;
                rel <= mem_rel;
            end else if (pend && wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else if (pend) begin
                pend <= 1'h0;
                mem_rvalid <= 1'h1;
                mem_rdata <= addr ^ (rel ? 16'hC33C : 16'h5AA5);
                mem_tag <= ^addr;
            end
        end
    end
endmodule // mst_mem_model

`default_nettype wire

// ### tb/testbench.sv
/*
 * Self-checking bench of the multiply/subtract/move datapath.
 * Assumes mst_mem_model as data memory and the plain register port.
 */
`timescale 1ns/100ps
`default_nettype none

module testbench;
    logic clock, resetn, cmd_valid, reg_wr, reg_rd, busy, done, illegal;
    logic mem_req, mem_rel, mem_tag, mem_rvalid;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, product_high_reg, product_low_reg;
    logic [15:0] mem_addr, mem_rdata, rd_v, m_mr, m_ph, m_pl;
    logic [15:0] m_acc [16];
    logic [3:0] m_ptr [4];
    logic [4:0] m_fl;
    logic [31:0] seed = 32'hA3A9;
    int n_mismatch = 0;
    int checked = 0;
    mst_pkg::mst_cmd_type cmd;
    mst_pkg::mst_flags_type flags;

    mst_mul_sub_xfer i_mst_mul_sub_xfer (.clock, .resetn, .cmd_valid, .cmd, .busy, .done,
        .illegal, .mem_req, .mem_addr, .mem_rel, .mem_rdata, .mem_tag, .mem_rvalid,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .product_high_reg,
        .product_low_reg, .flags);
    mst_mem_model i_mst_mem_model (.clock, .resetn, .mem_req, .mem_addr, .mem_rel,
        .mem_rdata, .mem_tag, .mem_rvalid);

    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    function automatic logic [15:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[15:0];
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        #1 rd_v = reg_rdata;
        @(posedge clock);
    endtask

    // offer one command, then wait a bounded time for done or illegal
    task automatic run(input logic [16:0] op, input logic [15:0] ext, input logic exp_busy,
                       output int cyc);
        int k;
        cmd <= {op, ext};
        cmd_valid <= 1'h1;
        @(posedge clock);
        cmd_valid <= 1'h0;
        for (k = 0; k < 40; k++) begin
            #1;
            if (k == 0) chk("busy_taken", {15'h0, exp_busy}, {15'h0, busy});
            if (done === 1'h1 || illegal === 1'h1) break;
            @(posedge clock);
        end
        cyc = k;
        if (k == 40) begin
            n_mismatch++;
            summarize();
        end
    endtask

    initial begin
        logic [16:0] op;
        logic [15:0] ext, a, b, r, s, c;
        logic [31:0] p;
        logic [1:0] sel, mo;
        logic [3:0] sb, db;
        logic bw, zr, mv;
        int kind, len, cyc;
        resetn = 1'h0;
        cmd_valid = 1'h0;
        cmd = '0;
        reg_addr = 8'h0;
        reg_wdata = 16'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        repeat (12) @(posedge clock);
        resetn <= 1'h1;
        @(posedge clock);
        for (int i = 0; i < 9; i++) begin
            rd(8'(i));
            chk("reset_value", 16'h0, rd_v);
        end
        wr(8'h02, 16'hFFFF);
        wr(8'h08, 16'hFFFF);
        rd(8'h02);
        chk("read_only_high", 16'h0, rd_v);
        rd(8'h08);
        chk("unmapped", 16'h0, rd_v);
        for (int i = 0; i < 16; i++) begin
            m_acc[i] = rnd();
            wr(8'h10 + 8'(i), m_acc[i]);
        end
        ext = rnd();
        wr(8'h05, ext);
        for (int i = 0; i < 4; i++) m_ptr[i] = ext[4*i +: 4];
        m_fl = 5'h0;
        // kinds: word sub, move, chain sub, memory sub, memory move, undecoded
        for (int it = 0; it < 48; it++) begin
            kind = it % 6;
            ext = rnd();
            sel = ext[9:8];
            m_mr = rnd();
            wr(8'h00, m_mr);
            mo = (kind == 2) ? 2'h3 : ((ext[11:10] == 2'h3) ? 2'h0 : ext[11:10]);
            len = (kind == 2) ? 32'(ext[13:12]) + 2 : ((kind == 5) ? 0 : 1);
            if (kind == 2) wr(8'h01, {14'h0, ext[13:12]});
            if (kind < 2) m_ptr[sel] = m_ptr[sel] + ((mo == 2'h1) ? 4'h1 : {4{mo[1]}});
            sb = m_ptr[sel] ^ {ext[1] && kind < 3, 3'h0};
            db = m_ptr[sel] ^ {ext[0] && kind < 3, 3'h0};
            if (kind < 3) op = {5'h1C, mo, sel, (kind == 1) ? 6'h36 : 6'h30, ext[1:0]};
            else op = {(kind == 3) ? 7'h3F : 7'h30, sel, ext[7:0]};
            if (kind == 5) op = {5'h1C, 2'h0, sel, 6'h3F, 2'h0};
            s = ext ^ (ext[7] ? 16'hC33C : 16'h5AA5);
            c = 16'h0;
            for (int k = 0; k < len; k++) begin
                p = m_mr * ((kind > 2) ? s : m_acc[4'(sb + k)]) + c;
                if (k == 0) m_pl = p[15:0];
                c = p[31:16];
            end
            m_ph = c;
            bw = 1'h0;
            zr = 1'h1;
            mv = (kind == 1 || kind == 4);
            for (int k = 0; k < len; k++) begin
                a = m_acc[4'(db + k)];
                b = (k == 0) ? m_pl : 16'h0;
                {bw, r} = {1'h0, a} - {1'h0, b} - {16'h0, bw};
                if (mv) r = m_pl;
                m_acc[4'(db + k)] = r;
                zr = zr && r == 16'h0;
            end
            if (kind != 5) m_fl = {(kind > 2) ? ^ext : m_fl[4],
                !mv && a[15] != b[15] && r[15] != a[15], r[15], zr, !mv && !bw};
            run(op, ext, kind != 5, cyc);
            if (kind == 5) chk("illegal", 16'h1, {15'h0, illegal});
            else begin
                chk("done", 16'h1, {15'h0, done});
                chk("busy_done", 16'h0, {15'h0, busy});
                if (kind < 3) chk("cycles", 16'(len), 16'(cyc));
                chk("product_high", m_ph, product_high_reg);
                chk("product_low", m_pl, product_low_reg);
                chk("flags", {11'h0, m_fl}, {11'h0, flags});
                for (int k = 0; k < len; k++) begin
                    rd(8'h10 + 8'(4'(db + k)));
                    chk("accum", m_acc[4'(db + k)], rd_v);
                end
                rd(8'h05);
                chk("pointers", {m_ptr[3], m_ptr[2], m_ptr[1], m_ptr[0]}, rd_v);
            end
        end
        summarize();
    end
endmodule // testbench

`default_nettype wire
